// file: verilog/ssl_led_top.sv
// status lamp driver of a safety laser scanner, with an ahb-lite register slave
// assumes status inputs arrive asynchronously from the evaluation logic and that
// the ahb-lite master issues single word transfers; the slave never inserts waits
`timescale 1ns/1ps
`default_nettype none
`include "ssl_cfg.svh"

// Behaviour
// - During the power-up self-test the red off lamp is lit steadily and the green on lamp is dark.
// - The startup phase lasts about ten seconds before the fixed startup pattern ends.
// - After startup every lamp shows the current operational status.
// - Lamp 1, red, is lit whenever the safety output pair is off.
// - Lamp 2, green, is lit whenever the safety output pair is on.
// - Lamp 3, yellow, is lit while any warning field sees an object and dark otherwise.
// - With manual reset, lamp 4 flashes while the restart interlock waits for reset.
// - With timed restart, lamp 4 is lit steadily while the restart delay counts down.
// - Three extra on and off lamp pairs copy the main red and green lamps exactly.
module ssl_led_top #(
  parameter int STARTUP_CYC = `SSL_STARTUP_CYC,
  parameter int FLASH_HALF_CYC = `SSL_FLASH_HALF_CYC,
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // status from the safety and evaluation logic
  input wire logic safe_on_in,
  input wire logic warn_hit_in,
  input wire logic intl_armed_in,
  input wire logic restart_count_in,
  // front status lamps
  output logic lamp_off_red,
  output logic lamp_on_green,
  output logic lamp_warn,
  output logic lamp_intl,
  // extra lamp pairs on the optics cover base
  output logic [2:0] lamp_off_extra,
  output logic [2:0] lamp_on_extra
);

  // ==========================================
  // elaboration checks
  if (STARTUP_CYC < 1) begin : g_bad_startup
    $error("startup count must be at least one cycle");
  end
  if (FLASH_HALF_CYC < 1) begin : g_bad_flash
    $error("flash half period must be at least one cycle");
  end

  // ==========================================
  // input synchroniser
  ssl_stat_if stat ();

  ssl_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .safe_on_raw(safe_on_in),
    .warn_raw(warn_hit_in),
    .armed_raw(intl_armed_in),
    .counting_raw(restart_count_in),
    .stat(stat)
  );

  // ==========================================
  // register file storage
  logic ctrl_timed_r;
  logic ctrl_timed_nxt;
  logic [31:0] flash_half_r;
  logic [31:0] flash_half_nxt;

  // ==========================================
  // ahb-lite address and data phase
  logic dp_wr_r;
  logic [7:0] dp_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic hreadyout_r;
  logic hresp_r;

  // a transfer is taken when selected, active and the bus is ready
  wire ap_take = hsel & htrans[`SSL_HTRANS_ACTIVE_BIT] & hready;
  // narrower writes are dropped; only whole words reach the registers
  wire ap_wr = ap_take & hwrite & (hsize == `SSL_HSIZE_WORD);
  wire ap_rd = ap_take & ~hwrite;
  wire [7:0] ap_addr = haddr[7:0];

  // write strobes in the data phase, when hwdata is on the bus
  wire wr_ctrl = dp_wr_r & (dp_addr_r == `SSL_ADDR_CTRL);
  wire wr_flash = dp_wr_r & (dp_addr_r == `SSL_ADDR_FLASH);

  assign ctrl_timed_nxt = wr_ctrl ? hwdata[`SSL_CTRL_TIMED_BIT] : ctrl_timed_r;
  assign flash_half_nxt = wr_flash ? hwdata : flash_half_r;

  // bus phase registers
  // zero wait states: ready and response are constant, so no transfer ever stalls
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
      hreadyout_r <= 1'b1;
      hresp_r <= `SSL_HRESP_OKAY;
    end else begin
      dp_wr_r <= ap_wr;
      dp_addr_r <= ap_addr;
      hreadyout_r <= 1'b1;
      hresp_r <= `SSL_HRESP_OKAY;
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_timed_r <= `SSL_CTRL_RESET;
      flash_half_r <= 32'(FLASH_HALF_CYC);
    end else begin
      ctrl_timed_r <= ctrl_timed_nxt;
      flash_half_r <= flash_half_nxt;
    end
  end

  // ==========================================
  // startup sequencing
  ssl_pkg::ssl_state_t state_r;
  ssl_pkg::ssl_state_t state_nxt;
  logic startup_tick;
  wire in_run = (state_r == ssl_pkg::st_run);

  // the startup length is a cycle count, so ten seconds assumes the nominal clock
  // one shot timer; held cleared once the run state is reached
  ssl_tmr #(
    .W(32)
  ) u_startup_tmr (
    .clk(clk),
    .rst_b(rst_b),
    .clr(in_run),
    .limit(32'(STARTUP_CYC)),
    .tick(startup_tick)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ssl_pkg::st_selftest: begin
        if (startup_tick) begin
          state_nxt = ssl_pkg::st_run;
        end
      end
      ssl_pkg::st_run: begin
        state_nxt = ssl_pkg::st_run;
      end
      default: begin
        // unknown code falls back to the safe fixed pattern
        state_nxt = ssl_pkg::st_selftest;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ssl_pkg::st_selftest;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================
  // flash generator
  logic flash_tick;
  logic flash_ph_r;

  // a shortened period takes effect within one old period, never stranding the count
  // free running so every flashing lamp shares one phase
  ssl_tmr #(
    .W(32)
  ) u_flash_tmr (
    .clk(clk),
    .rst_b(rst_b),
    .clr(1'b0),
    .limit(flash_half_r),
    .tick(flash_tick)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_ph_r <= 1'b0;
    end else if (flash_tick) begin
      flash_ph_r <= ~flash_ph_r;
    end
  end

  // ==========================================
  // lamp selection
  ssl_pkg::ssl_lamps_t run_set;
  ssl_pkg::ssl_lamps_t boot_set;
  ssl_pkg::ssl_lamps_t lamps_nxt;
  ssl_pkg::ssl_lamps_t lamps_r;

  // red and green from the one state bit, so they cannot both light
  assign run_set.red = ~stat.safe_on;
  assign run_set.green = stat.safe_on;
  assign run_set.warn = stat.warn_hit;
  // timed mode shows the countdown, manual mode flashes while armed
  assign run_set.intl = ctrl_timed_r ? stat.counting
                                     : (stat.armed & flash_ph_r);

  // the startup pattern ignores every status input, so live status is hidden meanwhile
  // fixed pattern while the self-tests run
  assign boot_set.red = 1'b1;
  assign boot_set.green = 1'b0;
  assign boot_set.warn = 1'b0;
  assign boot_set.intl = 1'b0;

  assign lamps_nxt = in_run ? run_set : boot_set;

  // lamp registers; reset shows the startup pattern at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lamps_r <= '{red: 1'b1, green: 1'b0, warn: 1'b0, intl: 1'b0};
    end else begin
      lamps_r <= lamps_nxt;
    end
  end

  // extra pairs copy the same next value, so they never lag the main pair
  logic [2:0] off_extra_r;
  logic [2:0] on_extra_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      off_extra_r <= 3'h7;
      on_extra_r <= 3'h0;
    end else begin
      off_extra_r <= {3{lamps_nxt.red}};
      on_extra_r <= {3{lamps_nxt.green}};
    end
  end

  // ==========================================
  // read data; _nxt values forward a write in the same cycle
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`SSL_ST_DONE_BIT] = in_run;
    status_word[`SSL_ST_SAFE_ON_BIT] = stat.safe_on;
    status_word[`SSL_ST_WARN_BIT] = stat.warn_hit;
    status_word[`SSL_ST_ARMED_BIT] = stat.armed;
    status_word[`SSL_ST_COUNT_BIT] = stat.counting;
    status_word[`SSL_ST_RED_BIT] = lamps_r.red;
    status_word[`SSL_ST_GREEN_BIT] = lamps_r.green;
    status_word[`SSL_ST_WLAMP_BIT] = lamps_r.warn;
    status_word[`SSL_ST_ILAMP_BIT] = lamps_r.intl;
    status_word[`SSL_ST_PHASE_BIT] = flash_ph_r;
  end

  // status reads show synchronised inputs, two cycles behind the pins
  wire sel_ctrl = (ap_addr == `SSL_ADDR_CTRL);
  wire sel_status = (ap_addr == `SSL_ADDR_STATUS);
  wire sel_flash = (ap_addr == `SSL_ADDR_FLASH);
  // unmapped addresses read as zero with an okay response
  assign hrdata_nxt = !ap_rd ? 32'h0000_0000 :
                      sel_ctrl ? {31'h0000_0000, ctrl_timed_nxt} :
                      sel_status ? status_word :
                      sel_flash ? flash_half_nxt : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_r <= 32'h0000_0000;
    end else begin
      hrdata_r <= hrdata_nxt;
    end
  end

  // ==========================================
  // outputs straight from flip-flops
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign lamp_off_red = lamps_r.red;
  assign lamp_on_green = lamps_r.green;
  assign lamp_warn = lamps_r.warn;
  assign lamp_intl = lamps_r.intl;
  assign lamp_off_extra = off_extra_r;
  assign lamp_on_extra = on_extra_r;

endmodule

`default_nettype wire

// file: verilog/ssl_cfg.svh
// constants for the scanner status lamp driver: timing, register map, field positions
// assumes a 100 MHz system clock; included by bare name from the top module and the testbench
`ifndef SSL_CFG_SVH
`define SSL_CFG_SVH

// ==========================================
// timing
`define SSL_CLK_KHZ 100000
`define SSL_STARTUP_MS 10000
`define SSL_FLASH_HALF_MS 250
// 10 s and 250 ms at 100 MHz, both well below 2^31
`define SSL_STARTUP_CYC (`SSL_STARTUP_MS * `SSL_CLK_KHZ)
`define SSL_FLASH_HALF_CYC (`SSL_FLASH_HALF_MS * `SSL_CLK_KHZ)

// ==========================================
// register map, byte addresses within the slave
`define SSL_ADDR_CTRL 8'h00
`define SSL_ADDR_STATUS 8'h04
`define SSL_ADDR_FLASH 8'h08
`define SSL_CTRL_RESET 1'b0

// ==========================================
// control fields
`define SSL_CTRL_TIMED_BIT 0

// ==========================================
// status fields
`define SSL_ST_DONE_BIT 0
`define SSL_ST_SAFE_ON_BIT 1
`define SSL_ST_WARN_BIT 2
`define SSL_ST_ARMED_BIT 3
`define SSL_ST_COUNT_BIT 4
`define SSL_ST_RED_BIT 5
`define SSL_ST_GREEN_BIT 6
`define SSL_ST_WLAMP_BIT 7
`define SSL_ST_ILAMP_BIT 8
`define SSL_ST_PHASE_BIT 9

// ==========================================
// ahb-lite encodings
`define SSL_HTRANS_ACTIVE_BIT 1
`define SSL_HSIZE_WORD 3'b010
`define SSL_HRESP_OKAY 1'b0

`endif

// file: verilog/ssl_pkg.sv
// types shared by the status lamp driver modules
// assumes nothing beyond a SystemVerilog compiler
package ssl_pkg;

  // ==========================================
  // startup sequencing
  typedef enum logic [1:0] {
    st_selftest = 2'b00,
    st_run = 2'b01
  } ssl_state_t;

  // ==========================================
  // one set of front lamps
  typedef struct packed {
    logic red;
    logic green;
    logic warn;
    logic intl;
  } ssl_lamps_t;

endpackage

// file: verilog/ssl_stat_if.sv
// synchronised status bundle between the input synchroniser and the lamp logic
// assumes both ends run on the one system clock
`timescale 1ns/1ps
`default_nettype none

interface ssl_stat_if;
  logic safe_on;
  logic warn_hit;
  logic armed;
  logic counting;

  // ==========================================
  // producer and consumer views
  modport src(output safe_on, output warn_hit, output armed, output counting);
  modport dst(input safe_on, input warn_hit, input armed, input counting);
endinterface

`default_nettype wire

// file: verilog/ssl_sync.sv
// multi-stage synchroniser for the four status inputs from the evaluation logic
// assumes the inputs may change at any time relative to clk
`timescale 1ns/1ps
`default_nettype none

module ssl_sync #(
  parameter int STAGES = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // raw status
  input wire logic safe_on_raw,
  input wire logic warn_raw,
  input wire logic armed_raw,
  input wire logic counting_raw,
  // synchronised status
  ssl_stat_if.src stat
);

  // ==========================================
  // elaboration check
  if (STAGES < 2) begin : g_bad_stages
    $error("ssl_sync needs at least two stages");
  end

  logic [3:0] pipe_r [STAGES];

  // ==========================================
  // shift chain; only the last stage is read outside
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < STAGES; i++) begin
        pipe_r[i] <= 4'h0;
      end
    end else begin
      pipe_r[0] <= {counting_raw, armed_raw, warn_raw, safe_on_raw};
      for (int i = 1; i < STAGES; i++) begin
        pipe_r[i] <= pipe_r[i-1];
      end
    end
  end

  assign stat.safe_on = pipe_r[STAGES-1][0];
  assign stat.warn_hit = pipe_r[STAGES-1][1];
  assign stat.armed = pipe_r[STAGES-1][2];
  assign stat.counting = pipe_r[STAGES-1][3];

endmodule

`default_nettype wire

// file: verilog/ssl_tmr.sv
// wrapping cycle counter giving a one-cycle tick every limit cycles
// assumes limit is steady or only changed between ticks; zero acts as one
`timescale 1ns/1ps
`default_nettype none

module ssl_tmr #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic clr,
  input wire logic [W-1:0] limit,
  // result
  output logic tick
);

  // ==========================================
  // elaboration check
  if (W < 2 || W > 32) begin : g_bad_width
    $error("ssl_tmr width must lie between 2 and 32");
  end

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic tick_r;
  wire [W-1:0] last = (limit == '0) ? '0 : limit - W'(1);
  // >= rather than == so a shrunk limit cannot strand the count
  wire wrap = (count_r >= last);

  assign count_nxt = clr ? '0 : (wrap ? '0 : count_r + W'(1));

  // ==========================================
  // counter and registered tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= '0;
      tick_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      tick_r <= wrap & ~clr;
    end
  end

  assign tick = tick_r;

endmodule

`default_nettype wire

// file: verification/ssl_led_top_properties.sv
// port checker for the status lamp driver, bound into ssl_led_top
// assumes one ahb-lite slave and status inputs that change right after a clock edge
`timescale 1ns/1ps
`default_nettype none

module ssl_led_top_chk #(
  parameter int STARTUP_CYC = 50
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // status
  input wire logic safe_on_in,
  input wire logic warn_hit_in,
  input wire logic intl_armed_in,
  input wire logic restart_count_in,
  // lamps
  input wire logic lamp_off_red,
  input wire logic lamp_on_green,
  input wire logic lamp_warn,
  input wire logic lamp_intl,
  input wire logic [2:0] lamp_off_extra,
  input wire logic [2:0] lamp_on_extra
);
  logic [31:0] cyc_r;
  // margin of 6 covers timer tick, state register and the 3-edge input path
  wire boot = (cyc_r < 32'(STARTUP_CYC));
  wire run = (cyc_r > 32'(STARTUP_CYC + 6));

  // ==========================================
  // cycles since reset release, saturating so it never wraps
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_r <= 32'h0;
    end else if (!run) begin
      cyc_r <= cyc_r + 32'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ==========================================
  // assertions
  a_boot_pattern: assert property (boot |-> lamp_off_red && !lamp_on_green && !lamp_warn && !lamp_intl) else $error("startup pattern wrong");
  a_red_follows: assert property (run |-> lamp_off_red == !$past(safe_on_in, 3)) else $error("red lamp wrong");
  a_green_follows: assert property (run |-> lamp_on_green == $past(safe_on_in, 3)) else $error("green lamp wrong");
  a_warn_follows: assert property (run |-> lamp_warn == $past(warn_hit_in, 3)) else $error("warn lamp wrong");
  a_intl_dark: assert property (run && !$past(intl_armed_in, 3) && !$past(restart_count_in, 3) |-> !lamp_intl) else $error("interlock lamp lit");
  a_extra_copy: assert property (lamp_off_extra == {3{lamp_off_red}} && lamp_on_extra == {3{lamp_on_green}}) else $error("extra lamps differ");
  a_never_both: assert property (!(lamp_off_red && lamp_on_green)) else $error("red and green lit");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus wait or error");
  a_rdata_idle: assert property (!$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == 32'h0) else $error("read data outside data phase");

  // ==========================================
  // scenario coverage
  c_green_on: cover property ($rose(lamp_on_green));
  c_intl_flash: cover property ($rose(lamp_intl) ##1 lamp_intl);
  c_read: cover property (hsel && htrans[1] && !hwrite);
endmodule

bind ssl_led_top ssl_led_top_chk #(.STARTUP_CYC(STARTUP_CYC)) u_chk (
  .clk(clk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .safe_on_in(safe_on_in), .warn_hit_in(warn_hit_in), .intl_armed_in(intl_armed_in),
  .restart_count_in(restart_count_in), .lamp_off_red(lamp_off_red),
  .lamp_on_green(lamp_on_green), .lamp_warn(lamp_warn), .lamp_intl(lamp_intl),
  .lamp_off_extra(lamp_off_extra), .lamp_on_extra(lamp_on_extra));

`default_nettype wire

// file: verification/ssl_led_top_tb.sv
// self-checking bench for the status lamp driver
// assumes a single ahb-lite slave whose hreadyout is the bus hready
`timescale 1ns/1ps
`default_nettype none
`include "ssl_cfg.svh"

module ssl_led_top_tb;
  localparam int SU = 50;
  localparam int FH = 8;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp;
  logic [31:0] hrdata, rd;
  logic safe_on = 1'h0, warn = 1'h0, armed = 1'h0, count = 1'h0;
  logic red, green, wl, il;
  logic [2:0] xoff, xon;
  int err_count = 0;
  int n_tests = 0;
  int n;

  assign hready = hreadyout;
  always #5 clk = ~clk;

  ssl_led_top #(.STARTUP_CYC(SU), .FLASH_HALF_CYC(FH)) u_dut (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .safe_on_in(safe_on),
    .warn_hit_in(warn), .intl_armed_in(armed), .restart_count_in(count),
    .lamp_off_red(red), .lamp_on_green(green), .lamp_warn(wl), .lamp_intl(il),
    .lamp_off_extra(xoff), .lamp_on_extra(xon));

  // ==========================================
  // compare and closing report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // red, green, warn, interlock lamps, then the extra pairs
  task automatic lamps(input logic [3:0] exp);
    chk({28'h0, red, green, wl, il}, {28'h0, exp});
    chk({26'h0, xoff, xon}, {26'h0, {3{exp[3]}}, {3{exp[2]}}});
  endtask

  // ==========================================
  // ahb-lite master; entered just after a rising edge
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (hready === 1'h1) break;
    end
    if (i == 20) begin
      err_count++;
      $display("ERROR %0t bus hang", $time);
      end_sim();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, `SSL_HRESP_OKAY});
  endtask

  // cycles for which the interlock lamp keeps level v, bounded
  task automatic run_len(input logic v, output int k);
    k = 0;
    while (il === v && k < 100) begin
      @(posedge clk);
      k++;
    end
    if (k == 100) begin
      err_count++;
      $display("ERROR %0t interlock lamp stuck", $time);
      end_sim();
    end
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    safe_on <= 1'h1;
    warn <= 1'h1;
    count <= 1'h1;
    repeat (SU - 2) @(posedge clk);
    lamps(4'h8);
    repeat (10) @(posedge clk);
    lamps(4'h6);
    bus(1'h0, `SSL_ADDR_STATUS, 32'h0);
    chk(rd & 32'h1ff, 32'hd7);
    bus(1'h0, `SSL_ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, `SSL_ADDR_FLASH, 32'h0);
    chk(rd, 32'(FH));
    bus(1'h0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    bus(1'h1, `SSL_ADDR_STATUS, 32'hffff_ffff);
    bus(1'h0, `SSL_ADDR_STATUS, 32'h0);
    chk(rd & 32'h1ff, 32'hd7);
    bus(1'h1, `SSL_ADDR_FLASH, 32'h5);
    bus(1'h0, `SSL_ADDR_FLASH, 32'h0);
    chk(rd, 32'h5);
    // safety outputs off, manual mode ignores the restart countdown
    safe_on <= 1'h0;
    warn <= 1'h0;
    repeat (4) @(posedge clk);
    lamps(4'h8);
    armed <= 1'h1;
    repeat (4) @(posedge clk);
    run_len(1'h1, n);
    run_len(1'h0, n);
    run_len(1'h1, n);
    chk(32'(n), 32'h5);
    run_len(1'h0, n);
    chk(32'(n), 32'h5);
    // a byte-sized write is dropped, the mode stays manual
    hsize <= 3'h0;
    bus(1'h1, `SSL_ADDR_CTRL, 32'h1);
    hsize <= 3'h2;
    bus(1'h0, `SSL_ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    // timed mode: steady while counting, armed no longer flashes
    bus(1'h1, `SSL_ADDR_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    lamps(4'h9);
    repeat (7) @(posedge clk);
    lamps(4'h9);
    count <= 1'h0;
    repeat (4) @(posedge clk);
    lamps(4'h8);
    // second reset mid-run; interlock released so manual mode shows dark
    safe_on <= 1'h1;
    armed <= 1'h0;
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    lamps(4'h8);
    rst_b <= 1'h1;
    bus(1'h0, `SSL_ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    repeat (SU - 6) @(posedge clk);
    lamps(4'h8);
    repeat (12) @(posedge clk);
    lamps(4'h4);
    end_sim();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("ERROR %0t run too long", $time);
    end_sim();
  end
endmodule

`default_nettype wire
